/* include/cwsr_defines.vh */
`ifndef CWSR_DEFINES_VH
`define CWSR_DEFINES_VH

// Word indices (byte address / 4)
`define CWSR_IDX_RX_COUNT   4'h0
`define CWSR_IDX_EARLY_RX   4'h1
`define CWSR_IDX_FLOW_CTRL  4'h2
`define CWSR_IDX_PM_DRIVER  4'h3
`define CWSR_IDX_GEN_CTRL   4'h4
`define CWSR_IDX_GEN_STATUS 4'h5
`define CWSR_IDX_FN_EVENT   4'hC
`define CWSR_IDX_FN_MASK    4'hD
`define CWSR_IDX_FN_PRESENT 4'hE
`define CWSR_IDX_FN_FORCE   4'hF

// Power-management driver fields
`define CWSR_PMD_LINK_CHG   31
`define CWSR_PMD_MAGIC      30
`define CWSR_PMD_MATCH      29
`define CWSR_PMD_OFFLOAD    25
`define CWSR_PMD_PME_STAT   24

// General control and status fields
`define CWSR_GC_CLKRUN_DIS  0
`define CWSR_GC_DEEP_PD     1
`define CWSR_GS_LINK        0
`define CWSR_GS_SPEED       1
`define CWSR_GS_DUPLEX      2

// Function event / mask fields
`define CWSR_FE_INTR        15
`define CWSR_FE_WKUP        14
`define CWSR_FE_GENERAL_WAKE_EVENT       4

// Flow control fields
`define CWSR_FC_CMD_LSB     16
`define CWSR_FC_THR_LSB     0

// Reset values
`define CWSR_RST_WORD       32'h00000000
`define CWSR_RST_BYTE       8'h00
`define CWSR_RST_FC_CMD     3'h0
`define CWSR_RST_FC_THR     13'h0000
`define CWSR_RST_ER_THR     16'h0000

`endif

/* src/cwsr_regs.v */
`timescale 1ns/10ps
`include "cwsr_defines.vh"

module cwsr_regs (
	// Clock, resets, enable
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        aux_powerup_reset_n_i,
	input  wire        ce_i,
	// Register access
	input  wire        csr_rd_i,
	input  wire        csr_wr_i,
	input  wire [5:0]  csr_addr_i,
	input  wire [3:0]  csr_be_i,
	input  wire [31:0] csr_wdata_i,
	output reg  [31:0] csr_rdata_o,
	output reg         csr_rvalid_o,
	// Mode and power state
	input  wire        cardbus_mode_i,
	input  wire [1:0]  power_state_i,
	input  wire        pme_enable_i,
	input  wire        pmcsr_pme_clear_i,
	input  wire        clk_needed_i,
	// Link and wake events
	input  wire        link_up_i,
	input  wire        full_duplex_i,
	input  wire        speed_100_i,
	input  wire        magic_frame_i,
	input  wire        wake_match_i,
	input  wire        offload_busy_i,
	input  wire        eth_int_src_i,
	// Receive path
	input  wire        rx_dma_valid_i,
	input  wire [2:0]  rx_dma_bytes_i,
	input  wire        rx_frame_start_i,
	input  wire [15:0] rx_frame_len_i,
	input  wire        early_rx_ack_i,
	// Status and control outputs
	output reg         early_rx_flag_o,
	output reg         inta_o,
	output reg         pme_o,
	output reg         pme_status_o,
	output reg         card_status_change_o,
	output reg         clk_request_o,
	output reg         deep_pd_allowed_o,
	output reg  [2:0]  flow_cmd_o,
	output reg  [12:0] flow_thresh_o
);

	// Register state, main reset
	reg [31:0] rx_count;
	reg [15:0] er_thresh;
	reg        er_armed;
	reg [1:0]  gen_ctrl;
	reg [2:0]  gen_status;

	// Register state, aux reset
	reg        link_q;
	reg        pmd_link_chg;
	reg        pmd_magic;
	reg        pmd_match;
	reg        pmd_offload;
	reg        fe_intr;
	reg        fe_general_wake_event;
	reg        fm_intr;
	reg        fm_wkup;
	reg        fm_general_wake_event;

	reg [31:0] next_rdata;

	wire [3:0]  idx;
	wire        wr;
	wire        csc_ok;
	wire [31:0] lane;
	wire [31:0] one_clr;
	wire        wr_rxc;
	wire        wr_er;
	wire        wr_fc;
	wire        wr_pmd;
	wire        wr_gc;
	wire        wr_fe;
	wire        wr_fm;
	wire        wr_ff;
	wire        link_evt;
	wire        wake_evt;
	wire        pme_clr;
	wire        general_wake_event_clr;
	wire        force_intr;
	wire        force_general_wake_event;
	wire        er_hit;

	assign idx    = csr_addr_i[5:2];
	assign wr     = ce_i & csr_wr_i;
	assign csc_ok = cardbus_mode_i;
	assign lane   = {{8{csr_be_i[3]}}, {8{csr_be_i[2]}},
	                 {8{csr_be_i[1]}}, {8{csr_be_i[0]}}};
	// Only written ones clear; zeros are ignored
	assign one_clr = csr_wdata_i & lane;

	assign wr_rxc = wr & (idx == `CWSR_IDX_RX_COUNT);
	assign wr_er  = wr & (idx == `CWSR_IDX_EARLY_RX);
	assign wr_fc  = wr & (idx == `CWSR_IDX_FLOW_CTRL);
	assign wr_pmd = wr & (idx == `CWSR_IDX_PM_DRIVER);
	assign wr_gc  = wr & (idx == `CWSR_IDX_GEN_CTRL);
	assign wr_fe  = wr & csc_ok & (idx == `CWSR_IDX_FN_EVENT);
	assign wr_fm  = wr & csc_ok & (idx == `CWSR_IDX_FN_MASK);
	assign wr_ff  = wr & csc_ok & (idx == `CWSR_IDX_FN_FORCE);

	assign link_evt = link_up_i ^ link_q;
	assign wake_evt = link_evt | magic_frame_i | wake_match_i;

	assign force_intr  = wr_ff & one_clr[`CWSR_FE_INTR];
	assign force_general_wake_event = wr_ff & one_clr[`CWSR_FE_GENERAL_WAKE_EVENT];

	// PME status drops on its own write, the PMCSR side, or wake bit
	assign pme_clr = (wr_pmd & one_clr[`CWSR_PMD_PME_STAT])
	               | pmcsr_pme_clear_i
	               | (wr_fe & one_clr[`CWSR_FE_GENERAL_WAKE_EVENT]);
	assign general_wake_event_clr = (wr_fe & one_clr[`CWSR_FE_GENERAL_WAKE_EVENT])
	                 | (wr_pmd & one_clr[`CWSR_PMD_PME_STAT]);

	assign er_hit = er_armed & (er_thresh != `CWSR_RST_ER_THR)
	              & (rx_frame_len_i >= er_thresh);

	// Receive byte count
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_count <= `CWSR_RST_WORD;
		end else if (ce_i) begin
			if (wr_rxc) begin
				rx_count <= `CWSR_RST_WORD;
			end else if (rx_dma_valid_i) begin
				rx_count <= rx_count + {29'h0, rx_dma_bytes_i};
			end
		end
	end

	// Early receive threshold and flag
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			er_thresh       <= `CWSR_RST_ER_THR;
			er_armed        <= 1'b0;
			early_rx_flag_o <= 1'b0;
		end else if (ce_i) begin
			if (wr_er) begin
				if (csr_be_i[0]) begin
					er_thresh[7:0] <= csr_wdata_i[7:0];
				end
				if (csr_be_i[1]) begin
					er_thresh[15:8] <= csr_wdata_i[15:8];
				end
			end
			// One early indication per frame
			if (rx_frame_start_i) begin
				er_armed <= 1'b1;
			end else if (er_hit) begin
				er_armed <= 1'b0;
			end
			if (er_hit) begin
				early_rx_flag_o <= 1'b1;
			end else if (early_rx_ack_i) begin
				early_rx_flag_o <= 1'b0;
			end
		end
	end

	// Flow control and general control
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flow_cmd_o    <= `CWSR_RST_FC_CMD;
			flow_thresh_o <= `CWSR_RST_FC_THR;
			gen_ctrl      <= 2'h0;
		end else if (ce_i) begin
			if (wr_fc & csr_be_i[2]) begin
				flow_cmd_o <= csr_wdata_i[`CWSR_FC_CMD_LSB +: 3];
			end
			if (wr_fc & csr_be_i[0]) begin
				flow_thresh_o[7:0] <= csr_wdata_i[7:0];
			end
			if (wr_fc & csr_be_i[1]) begin
				flow_thresh_o[12:8] <= csr_wdata_i[12:8];
			end
			if (wr_gc & csr_be_i[0]) begin
				gen_ctrl <= csr_wdata_i[1:0];
			end
		end
	end

	// General status snapshot of the link
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gen_status <= 3'h0;
		end else if (ce_i) begin
			gen_status[`CWSR_GS_LINK]   <= link_up_i;
			gen_status[`CWSR_GS_SPEED]  <= speed_100_i;
			gen_status[`CWSR_GS_DUPLEX] <= full_duplex_i;
		end
	end

	// Driver indication bits, aux reset only; set beats clear
	always @(posedge clk_i or negedge aux_powerup_reset_n_i) begin
		if (!aux_powerup_reset_n_i) begin
			link_q       <= 1'b0;
			pmd_link_chg <= 1'b0;
			pmd_magic    <= 1'b0;
			pmd_match    <= 1'b0;
			pmd_offload  <= 1'b0;
			pme_status_o <= 1'b0;
		end else if (ce_i) begin
			link_q <= link_up_i;
			if (link_evt) begin
				pmd_link_chg <= 1'b1;
			end else if (wr_pmd & one_clr[`CWSR_PMD_LINK_CHG]) begin
				pmd_link_chg <= 1'b0;
			end
			if (magic_frame_i) begin
				pmd_magic <= 1'b1;
			end else if (wr_pmd & one_clr[`CWSR_PMD_MAGIC]) begin
				pmd_magic <= 1'b0;
			end
			if (wake_match_i) begin
				pmd_match <= 1'b1;
			end else if (wr_pmd & one_clr[`CWSR_PMD_MATCH]) begin
				pmd_match <= 1'b0;
			end
			if (offload_busy_i) begin
				pmd_offload <= 1'b1;
			end else if (wr_pmd & one_clr[`CWSR_PMD_OFFLOAD]) begin
				pmd_offload <= 1'b0;
			end
			if (wake_evt) begin
				pme_status_o <= 1'b1;
			end else if (pme_clr) begin
				pme_status_o <= 1'b0;
			end
		end
	end

	// Card status change event and mask, aux reset
	always @(posedge clk_i or negedge aux_powerup_reset_n_i) begin
		if (!aux_powerup_reset_n_i) begin
			fe_intr  <= 1'b0;
			fe_general_wake_event <= 1'b0;
			fm_intr  <= 1'b0;
			fm_wkup  <= 1'b0;
			fm_general_wake_event <= 1'b0;
		end else if (ce_i) begin
			if (eth_int_src_i | force_intr) begin
				fe_intr <= 1'b1;
			end else if (wr_fe & one_clr[`CWSR_FE_INTR]) begin
				fe_intr <= 1'b0;
			end
			if (wake_evt | force_general_wake_event) begin
				fe_general_wake_event <= 1'b1;
			end else if (general_wake_event_clr) begin
				fe_general_wake_event <= 1'b0;
			end
			if (wr_fm & csr_be_i[1]) begin
				fm_intr <= csr_wdata_i[`CWSR_FE_INTR];
				fm_wkup <= csr_wdata_i[`CWSR_FE_WKUP];
			end
			if (wr_fm & csr_be_i[0]) begin
				fm_general_wake_event <= csr_wdata_i[`CWSR_FE_GENERAL_WAKE_EVENT];
			end
		end
	end

	// Wake signalling: PME in PCI mode, status change in CardBus
	always @(posedge clk_i or negedge aux_powerup_reset_n_i) begin
		if (!aux_powerup_reset_n_i) begin
			pme_o                <= 1'b0;
			card_status_change_o <= 1'b0;
		end else if (ce_i) begin
			pme_o <= ~cardbus_mode_i & pme_enable_i & pme_status_o;
			card_status_change_o <= cardbus_mode_i
				& ((fm_wkup & fm_general_wake_event & fe_general_wake_event)
				| (pme_enable_i & pme_status_o));
		end
	end

	// Interrupt, clock request and deep power-down permission
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			inta_o            <= 1'b0;
			clk_request_o     <= 1'b0;
			deep_pd_allowed_o <= 1'b0;
		end else if (ce_i) begin
			inta_o <= early_rx_flag_o
				| (eth_int_src_i & (~cardbus_mode_i | fm_intr));
			clk_request_o <= gen_ctrl[`CWSR_GC_CLKRUN_DIS]
				| clk_needed_i;
			// D2 and D3 both have the upper state bit set
			deep_pd_allowed_o <= gen_ctrl[`CWSR_GC_DEEP_PD]
				& ~link_up_i & power_state_i[1];
		end
	end

	// Read multiplexer; unmapped and blocked words read zero
	always @* begin
		next_rdata = `CWSR_RST_WORD;
		case (idx)
		`CWSR_IDX_RX_COUNT: begin
			next_rdata = rx_count;
		end
		`CWSR_IDX_EARLY_RX: begin
			next_rdata[15:0] = er_thresh;
		end
		`CWSR_IDX_FLOW_CTRL: begin
			next_rdata[`CWSR_FC_CMD_LSB +: 3] = flow_cmd_o;
			next_rdata[`CWSR_FC_THR_LSB +: 13] = flow_thresh_o;
		end
		`CWSR_IDX_PM_DRIVER: begin
			next_rdata[`CWSR_PMD_LINK_CHG] = pmd_link_chg;
			next_rdata[`CWSR_PMD_MAGIC]    = pmd_magic;
			next_rdata[`CWSR_PMD_MATCH]    = pmd_match;
			next_rdata[28:26]              = 3'h0;
			next_rdata[`CWSR_PMD_OFFLOAD]  = pmd_offload;
			next_rdata[`CWSR_PMD_PME_STAT] = pme_status_o;
		end
		`CWSR_IDX_GEN_CTRL: begin
			next_rdata[1:0] = gen_ctrl;
		end
		`CWSR_IDX_GEN_STATUS: begin
			next_rdata[2:0] = gen_status;
		end
		`CWSR_IDX_FN_EVENT: begin
			if (csc_ok) begin
				next_rdata[`CWSR_FE_INTR]  = fe_intr;
				next_rdata[`CWSR_FE_GENERAL_WAKE_EVENT] = fe_general_wake_event;
			end
		end
		`CWSR_IDX_FN_MASK: begin
			if (csc_ok) begin
				next_rdata[`CWSR_FE_INTR]  = fm_intr;
				next_rdata[`CWSR_FE_WKUP]  = fm_wkup;
				next_rdata[`CWSR_FE_GENERAL_WAKE_EVENT] = fm_general_wake_event;
			end
		end
		`CWSR_IDX_FN_PRESENT: begin
			if (csc_ok) begin
				next_rdata[`CWSR_FE_INTR]  = eth_int_src_i;
				next_rdata[`CWSR_FE_GENERAL_WAKE_EVENT] = pme_status_o;
			end
		end
		default: begin
			next_rdata = `CWSR_RST_WORD;
		end
		endcase
	end

	// Registered read answer, one cycle after the strobe
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			csr_rdata_o  <= `CWSR_RST_WORD;
			csr_rvalid_o <= 1'b0;
		end else if (ce_i) begin
			csr_rvalid_o <= csr_rd_i;
			if (csr_rd_i) begin
				csr_rdata_o <= next_rdata;
			end
		end
	end

endmodule // cwsr_regs

/* sim/cwsr_regs_sva.sv */
`timescale 1ns/10ps
module cwsr_regs_sva (
	input wire        clk_i,
	input wire        rst_i,
	input wire        aux_powerup_reset_n_i,
	input wire        ce_i,
	input wire        csr_rd_i,
	input wire [5:0]  csr_addr_i,
	input wire [31:0] csr_rdata_o,
	input wire        csr_rvalid_o,
	input wire        cardbus_mode_i,
	input wire [1:0]  power_state_i,
	input wire        pmcsr_pme_clear_i,
	input wire        clk_needed_i,
	input wire        link_up_i,
	input wire        full_duplex_i,
	input wire        speed_100_i,
	input wire        magic_frame_i,
	input wire        wake_match_i,
	input wire        early_rx_flag_o,
	input wire        inta_o,
	input wire        pme_o,
	input wire        pme_status_o,
	input wire        card_status_change_o,
	input wire        clk_request_o,
	input wire        deep_pd_allowed_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || !aux_powerup_reset_n_i);
	property p_rvalid; ce_i |=> csr_rvalid_o == $past(csr_rd_i); endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read answer timing wrong");
	property p_rsvd; csr_rvalid_o && $past(csr_addr_i[5:2]) == 4'h3
		|-> csr_rdata_o[28:26] == 3'h0; endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved driver bits not zero");
	property p_status; csr_rvalid_o && $past(csr_addr_i[5:2]) == 4'h5
		|-> csr_rdata_o == {29'h0, $past(full_duplex_i, 2),
		$past(speed_100_i, 2), $past(link_up_i, 2)}; endproperty
	a_status: assert property (p_status)
		else $error("status word wrong");
	property p_clk; ce_i && clk_needed_i |=> clk_request_o; endproperty
	a_clk: assert property (p_clk)
		else $error("clock request dropped");
	property p_deep; ce_i && (link_up_i || !power_state_i[1])
		|=> !deep_pd_allowed_o; endproperty
	a_deep: assert property (p_deep)
		else $error("deep power-down while not allowed");
	property p_early; ce_i && early_rx_flag_o |=> inta_o; endproperty
	a_early: assert property (p_early)
		else $error("early receive without interrupt");
	property p_wake; ce_i && (magic_frame_i || wake_match_i)
		|=> pme_status_o; endproperty
	a_wake: assert property (p_wake)
		else $error("wake event missed");
	// Link history is cleared by the aux reset and frozen by ce_i
	property p_clear; ce_i && $past(ce_i)
		&& $past(aux_powerup_reset_n_i)
		&& pmcsr_pme_clear_i && !magic_frame_i
		&& !wake_match_i && $stable(link_up_i)
		|=> !pme_status_o ##1 !pme_o; endproperty
	a_clear: assert property (p_clear)
		else $error("status clear ignored");
	property p_mode; ce_i && cardbus_mode_i |=> !pme_o; endproperty
	a_mode: assert property (p_mode)
		else $error("wake line active in card mode");
	c_read: cover property (csr_rvalid_o);
	c_pme: cover property (pme_o);
	c_csc: cover property (card_status_change_o);
endmodule // cwsr_regs_sva

bind cwsr_regs cwsr_regs_sva u_sva (.*);

/* sim/cwsr_host.sv */
`timescale 1ns/10ps
module cwsr_host (
	// Clock and answer
	input  wire        clk_i,
	input  wire [31:0] rdata_i,
	input  wire        rvalid_i,
	// Request
	output reg         rd_o,
	output reg         wr_o,
	output reg  [5:0]  addr_o,
	output reg  [31:0] wdata_o
);
	initial {rd_o, wr_o, addr_o, wdata_o} = 40'h0;
	task wr(input [5:0] a, input [31:0] d);
		begin
			@(posedge clk_i) #1;
			wr_o = 1'h1;
			addr_o = a;
			wdata_o = d;
			@(posedge clk_i) #1;
			wr_o = 1'h0;
			// Released data does not keep its value
			wdata_o = ~d;
		end
	endtask
	// Answer comes exactly one cycle after the strobe
	task rd(input [5:0] a, output [31:0] d);
		begin
			@(posedge clk_i) #1;
			rd_o = 1'h1;
			addr_o = a;
			@(posedge clk_i) #1;
			rd_o = 1'h0;
			d = rvalid_i ? rdata_i : 32'hXXXXXXXX;
		end
	endtask
endmodule // cwsr_host

/* sim/cardbus_wake_status_regs_test.sv */
`timescale 1ns/10ps
module cardbus_wake_status_regs_test;
	reg         clk_i, rst_i, aux_powerup_reset_n_i, ce_i;
	reg         cardbus_mode_i, pme_enable_i, pmcsr_pme_clear_i;
	reg         clk_needed_i, link_up_i, full_duplex_i, speed_100_i;
	reg         magic_frame_i, wake_match_i, offload_busy_i;
	reg         eth_int_src_i, rx_dma_valid_i, rx_frame_start_i;
	reg         early_rx_ack_i;
	reg  [1:0]  power_state_i;
	reg  [2:0]  rx_dma_bytes_i;
	reg  [15:0] rx_frame_len_i;
	wire        csr_rd_i, csr_wr_i, csr_rvalid_o, early_rx_flag_o;
	wire        inta_o, pme_o, pme_status_o, card_status_change_o;
	wire        clk_request_o, deep_pd_allowed_o;
	wire [5:0]  csr_addr_i;
	wire [3:0]  csr_be_i = 4'hF;
	wire [31:0] csr_wdata_i, csr_rdata_o;
	wire [2:0]  flow_cmd_o;
	wire [12:0] flow_thresh_o;
	integer     miscompares, n_tests;
	cwsr_regs dut (.*);
	cwsr_host h (.clk_i(clk_i), .rdata_i(csr_rdata_o),
		.rvalid_i(csr_rvalid_o), .rd_o(csr_rd_i), .wr_o(csr_wr_i),
		.addr_o(csr_addr_i), .wdata_o(csr_wdata_i));
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", n_tests, miscompares);
			if (miscompares == 0 && n_tests > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
			end
		end
	endtask
	task rc(input [5:0] a, input [31:0] e);
		reg [31:0] d;
		begin
			h.rd(a, d);
			check(d, e);
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk_i);
			#1;
		end
	endtask
	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#40000;
		miscompares = miscompares + 1;
		tally_and_finish;
	end
	initial begin
		{cardbus_mode_i, pme_enable_i, pmcsr_pme_clear_i, clk_needed_i,
			link_up_i, full_duplex_i, speed_100_i, magic_frame_i,
			wake_match_i, offload_busy_i, eth_int_src_i, rx_dma_valid_i,
			rx_frame_start_i, early_rx_ack_i, power_state_i,
			rx_dma_bytes_i, rx_frame_len_i} = 35'h0;
		{miscompares, n_tests} = 64'h0;
		{ce_i, rst_i, aux_powerup_reset_n_i} = 3'h6;
		tick(3);
		{rst_i, aux_powerup_reset_n_i} = 2'h1;
		rc(6'h14, 32'h0);
		rc(6'h0C, 32'h0);
		{link_up_i, full_duplex_i, speed_100_i} = 3'h7;
		tick(2);
		rc(6'h14, 32'h7);
		rc(6'h0C, 32'h81000000);
		h.wr(6'h0C, 32'h0);
		rc(6'h0C, 32'h81000000);
		h.wr(6'h0C, 32'h80000000);
		rc(6'h0C, 32'h01000000);
		h.wr(6'h0C, 32'h01000000);
		rc(6'h0C, 32'h0);
		$display("test 1 done");
		{pme_enable_i, magic_frame_i} = 2'h3;
		tick(1);
		{magic_frame_i, wake_match_i} = 2'h1;
		tick(1);
		{wake_match_i, offload_busy_i} = 2'h1;
		tick(2);
		check(pme_o, 1'h1);
		rc(6'h0C, 32'h63000000);
		pmcsr_pme_clear_i = 1'h1;
		tick(1);
		{pmcsr_pme_clear_i, offload_busy_i} = 2'h0;
		tick(1);
		check(pme_o, 1'h0);
		h.wr(6'h0C, 32'hFFFFFFFF);
		rc(6'h0C, 32'h0);
		magic_frame_i = 1'h1;
		tick(1);
		magic_frame_i = 1'h0;
		h.wr(6'h10, 32'h3);
		rst_i = 1'h1;
		tick(2);
		rst_i = 1'h0;
		rc(6'h0C, 32'h41000000);
		rc(6'h10, 32'h0);
		aux_powerup_reset_n_i = 1'h0;
		tick(2);
		aux_powerup_reset_n_i = 1'h1;
		rc(6'h0C, 32'h81000000);
		$display("test 2 done");
		h.wr(6'h10, 32'h1);
		tick(1);
		check(clk_request_o, 1'h1);
		h.wr(6'h10, 32'h2);
		clk_needed_i = 1'h1;
		tick(2);
		check(clk_request_o, 1'h1);
		{clk_needed_i, link_up_i, power_state_i} = 4'h3;
		tick(2);
		check(deep_pd_allowed_o, 1'h1);
		check(clk_request_o, 1'h0);
		power_state_i = 2'h0;
		tick(2);
		check(deep_pd_allowed_o, 1'h0);
		h.wr(6'h0C, 32'hFFFFFFFF);
		h.wr(6'h00, 32'h0);
		{rx_dma_valid_i, rx_dma_bytes_i} = 4'hF;
		tick(2);
		rx_dma_bytes_i = 3'h5;
		tick(1);
		rx_dma_valid_i = 1'h0;
		rc(6'h00, 32'h13);
		$display("test 3 done");
		h.wr(6'h04, 32'h40);
		{rx_frame_start_i, rx_frame_len_i} = 17'h1003F;
		tick(1);
		rx_frame_start_i = 1'h0;
		tick(2);
		check(early_rx_flag_o, 1'h0);
		rx_frame_len_i = 16'h0040;
		tick(3);
		check(early_rx_flag_o, 1'h1);
		check(inta_o, 1'h1);
		early_rx_ack_i = 1'h1;
		tick(1);
		early_rx_ack_i = 1'h0;
		tick(2);
		check(inta_o, 1'h0);
		h.wr(6'h08, 32'h00051ABC);
		tick(1);
		check({flow_cmd_o, flow_thresh_o}, 16'hBABC);
		rc(6'h08, 32'h00051ABC);
		$display("test 4 done");
		{cardbus_mode_i, pme_enable_i} = 2'h2;
		h.wr(6'h34, 32'h4010);
		h.wr(6'h3C, 32'hFFFF);
		tick(1);
		check(card_status_change_o, 1'h1);
		rc(6'h30, 32'h8010);
		rc(6'h3C, 32'h0);
		h.wr(6'h0C, 32'h01000000);
		rc(6'h30, 32'h8000);
		h.wr(6'h30, 32'h8000);
		rc(6'h30, 32'h0);
		eth_int_src_i = 1'h1;
		tick(2);
		check({card_status_change_o, inta_o}, 2'h0);
		h.wr(6'h34, 32'hC010);
		tick(1);
		check(inta_o, 1'h1);
		rc(6'h38, 32'h8000);
		// Frozen by the clock enable: the wake frame is not seen
		ce_i = 1'h0;
		magic_frame_i = 1'h1;
		tick(2);
		{ce_i, magic_frame_i} = 2'h2;
		rc(6'h0C, 32'h0);
		$display("test 5 done");
		tally_and_finish;
	end
endmodule // cardbus_wake_status_regs_test
